// [rtl/stage_cfg_pkg.sv]
// Purpose: shared constants, types and reset values of the stage axis configuration logic
// Assumes: 10 MHz clock, 32-bit register port with byte offsets
// Notes:   all state of the main module is one packed struct declared here
//
// What this block does
// - master addresses at most eight axes, 0..7
// - show axis count four seconds, then dot flashes
// - driver indicator flashes when linked without fault
// - indicator steady when master absent or faulty
// - hex divide switch decoded through fixed table
// - divide defaults to twenty divisions
// - host divide-change command is ignored
// - host talks only over selected interface
// - network address and mask have fixed defaults
// - power-up profile chosen by stored select, default 1
// - profile holds min, max, ramp; ramp 1..1000
// - legacy pulse mode or native length mode
// - output polarity follows stored output-level setting
// - display enable switches display and indicators
// - disabled display still lights on abnormal condition
// - serial handshake uses rts/cts when enabled
package stage_cfg_pkg;

  // timing
  localparam int unsigned CLK_HZ          = 10_000_000;          // system clock rate
  localparam int unsigned SHOW_TIME_MS    = 4000;                // axis count display time
  localparam int unsigned SHOW_CYCLES     = SHOW_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_HALF_MS   = 250;                 // flash half period
  localparam int unsigned FLASH_CYCLES    = FLASH_HALF_MS * (CLK_HZ / 1000);

  // sizes
  localparam int unsigned MAX_AXES        = 8;                   // link addresses 0..7
  localparam int unsigned IO_WIDTH        = 4;                   // general output pins

  // register byte offsets
  localparam logic [7:0] OFS_CTRL         = 8'h00;               // configuration bits
  localparam logic [7:0] OFS_IP           = 8'h04;               // network address
  localparam logic [7:0] OFS_MASK         = 8'h08;               // subnet mask
  localparam logic [7:0] OFS_LOAD         = 8'h0c;               // reload active profile
  localparam logic [7:0] OFS_STATUS       = 8'h10;               // read-only status
  localparam logic [7:0] OFS_DIVCMD       = 8'h14;               // host divide command
  localparam logic [1:0] PROF_PAGE        = 2'h1;                // addr[7:6] of profiles
  localparam logic [1:0] FLD_MIN          = 2'h0;                // addr[3:2] minimum speed
  localparam logic [1:0] FLD_MAX          = 2'h1;                // addr[3:2] maximum speed
  localparam logic [1:0] FLD_RAMP         = 2'h2;                // addr[3:2] ramp time

  // host interface codes
  localparam logic [1:0] LINK_SERIAL      = 2'h0;
  localparam logic [1:0] LINK_USB         = 2'h1;
  localparam logic [1:0] LINK_ETH         = 2'h2;

  // value limits and defaults
  localparam logic [15:0] RAMP_LO         = 16'h0001;            // 1 ms
  localparam logic [15:0] RAMP_HI         = 16'h03e8;            // 1000 ms
  localparam logic [15:0] RAMP_DEF        = 16'h00c8;            // 200 ms
  localparam logic [31:0] IP_DEF          = 32'hc0a8_0001;       // 192.168.0.1
  localparam logic [31:0] MASK_DEF        = 32'hffff_ff00;       // 255.255.255.0
  localparam logic [7:0]  DIV_DEF         = 8'h14;               // 20 divisions
  localparam logic [3:0]  DIV_CODE_BAD    = 4'h2;                // unusable switch code

  // divide table, index 15 first
  localparam logic [15:0][7:0] DIV_TABLE  = '{8'hfa, 8'hc8, 8'h7d, 8'h64,
                                              8'h50, 8'h32, 8'h28, 8'h19,
                                              8'h14, 8'h0a, 8'h08, 8'h05,
                                              8'h04, 8'h00, 8'h02, 8'h01};

  // boot sequence of the master display
  typedef enum logic [1:0] {ST_BOOT, ST_SHOW, ST_RUN} boot_t;

  // stored configuration bits, register layout msb first
  typedef struct packed {
    logic [1:0] speed_sel;                // profile 1..4 as 0..3
    logic       display_enable;           // display and indicators on
    logic       idle_low;                 // outputs idle low, active high
    logic       legacy_pulse_unit_mode;   // legacy pulse unit mode
    logic       serial_handshake_enable;  // rts/cts on serial link
    logic [1:0] host_link_choice;         // selected host interface
  } cfg_t;

  // one speed profile
  typedef struct packed {
    logic [31:0] min_speed;
    logic [31:0] max_speed;
    logic [15:0] ramp_ms;
  } profile_t;

  // whole state of the main module
  typedef struct packed {
    cfg_t                 cfg;
    logic [31:0]          ip;
    logic [31:0]          mask;
    profile_t [3:0]       prof;
    profile_t             active;
    boot_t                boot;
    logic [31:0]          cnt;
    logic [31:0]          flash_cnt;
    logic                 flash;
    logic [31:0]          rdata;
    logic [3:0]           seg_count;
    logic                 seg_on;
    logic                 dot_on;
    logic                 driver_led;
    logic                 motor_enable;
    logic [7:0]           divide_value;
    logic [IO_WIDTH-1:0]  io_pin;
  } state_t;

  localparam cfg_t CFG_DEF = '{speed_sel: 2'h0, display_enable: 1'b1, idle_low: 1'b0,
                               legacy_pulse_unit_mode: 1'b0, serial_handshake_enable: 1'b1,
                               host_link_choice: LINK_SERIAL};

  localparam profile_t [3:0] PROF_DEF = '{
    '{32'h0001_86a0, 32'h000f_4240, RAMP_DEF},
    '{32'h0001_1170, 32'h000a_ae60, RAMP_DEF},
    '{32'h0000_7530, 32'h0004_93e0, RAMP_DEF},
    '{32'h0000_2710, 32'h0001_86a0, RAMP_DEF}};

endpackage : stage_cfg_pkg

// [rtl/divide_decode.sv]
// Purpose: decode of the stepper unit hex divide switch
// Assumes: switch level is synchronous to the clock
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module divide_decode
(
  input  wire logic [3:0] code,      // hex switch position
  output logic      [7:0] divide,    // divisions per full step
  output logic            unusable   // switch on the unusable position
);

  // table lookup of the divide value
  always_comb
  begin
    divide   = stage_cfg_pkg::DIV_TABLE[code];
    unusable = (code == stage_cfg_pkg::DIV_CODE_BAD);
  end

endmodule : divide_decode
`default_nettype wire

// [rtl/stage_axis_config_logic.sv]
// Purpose: stored settings, boot display, indicators and divide decode of the stage controller
// Assumes: all inputs synchronous to clk; register port answers reads one cycle later
// Notes:   all state sits in one packed struct, filled by one comb process
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module stage_axis_config_logic
#(
  parameter int unsigned SHOW_CYCLES  = stage_cfg_pkg::SHOW_CYCLES,   // count display time
  parameter int unsigned FLASH_CYCLES = stage_cfg_pkg::FLASH_CYCLES   // flash half period
)
(
  input  wire logic                                 clk,
  input  wire logic                                 reset_n,
  input  wire logic [7:0]                           addr,
  input  wire logic [31:0]                          wdata,
  input  wire logic                                 wr,
  input  wire logic                                 rd,
  output logic      [31:0]                          rdata,
  input  wire logic [stage_cfg_pkg::MAX_AXES-1:0]   axis_present,
  input  wire logic                                 term_seen,
  input  wire logic                                 link_fault,
  input  wire logic                                 master_link_up,
  input  wire logic [3:0]                           divide_switch,
  input  wire logic                                 cts,
  input  wire logic                                 host_rx_ready,
  input  wire logic [stage_cfg_pkg::IO_WIDTH-1:0]   io_active,
  output logic      [3:0]                           seg_count,
  output logic                                      seg_on,
  output logic                                      dot_on,
  output logic                                      driver_led,
  output logic                                      motor_enable,
  output logic      [7:0]                           divide_value,
  output logic      [2:0]                           host_en,
  output logic                                      rts,
  output logic                                      tx_allow,
  output logic      [stage_cfg_pkg::IO_WIDTH-1:0]   io_pin,
  output logic                                      legacy_pulse_unit_mode,
  output stage_cfg_pkg::profile_t                   active_profile,
  output logic      [31:0]                          ip_addr,
  output logic      [31:0]                          net_mask
);

  stage_cfg_pkg::state_t st;        // registered state
  stage_cfg_pkg::state_t next_st;   // next state
  logic [7:0]            dec_divide;  // decoded switch value
  logic                  dec_bad;     // switch on unusable code
  logic                  abnormal;    // any fault or missing terminator
  logic                  healthy;     // local driver linked cleanly
  logic [1:0]            prof_idx;    // profile addressed by the bus
  logic [1:0]            prof_fld;    // field addressed by the bus
  logic                  prof_hit;    // bus address in profile page

  // reset value of the whole state
  localparam stage_cfg_pkg::state_t STATE_RESET = '{
    cfg: stage_cfg_pkg::CFG_DEF, ip: stage_cfg_pkg::IP_DEF, mask: stage_cfg_pkg::MASK_DEF,
    prof: stage_cfg_pkg::PROF_DEF, active: stage_cfg_pkg::PROF_DEF[0],
    boot: stage_cfg_pkg::ST_BOOT, cnt: 32'h0, flash_cnt: 32'h0, flash: 1'b0,
    rdata: 32'h0, seg_count: 4'h0, seg_on: 1'b1, dot_on: 1'b0, driver_led: 1'b1,
    motor_enable: 1'b0, divide_value: stage_cfg_pkg::DIV_DEF, io_pin: '1};

  // number of responding axes over the eight link addresses
  function automatic logic [3:0] count_axes(input logic [stage_cfg_pkg::MAX_AXES-1:0] p);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < stage_cfg_pkg::MAX_AXES; i++)
    begin
      n = n + {3'h0, p[i]};
    end
    return n;
  endfunction : count_axes

  // switch decode
  divide_decode u_divide_decode
  (
    .code     (divide_switch),
    .divide   (dec_divide),
    .unusable (dec_bad)
  );

  // address split of the profile page
  assign prof_hit = (addr[7:6] == stage_cfg_pkg::PROF_PAGE);
  assign prof_idx = addr[5:4];
  assign prof_fld = addr[3:2];

  // condition flags
  assign abnormal = link_fault || dec_bad || !term_seen;
  assign healthy  = master_link_up && !link_fault && !dec_bad;

  // next state
  always_comb
  begin
    next_st       = st;
    next_st.rdata = 32'h0;
    // register reads, unmapped reads give zero
    if (rd)
    begin
      if (prof_hit)
      begin
        case (prof_fld)
          stage_cfg_pkg::FLD_MIN:  next_st.rdata = st.prof[prof_idx].min_speed;
          stage_cfg_pkg::FLD_MAX:  next_st.rdata = st.prof[prof_idx].max_speed;
          stage_cfg_pkg::FLD_RAMP: next_st.rdata = {16'h0, st.prof[prof_idx].ramp_ms};
          default:                 next_st.rdata = 32'h0;
        endcase
      end
      else
      begin
        case (addr)
          stage_cfg_pkg::OFS_CTRL:   next_st.rdata = {24'h0, st.cfg};
          stage_cfg_pkg::OFS_IP:     next_st.rdata = st.ip;
          stage_cfg_pkg::OFS_MASK:   next_st.rdata = st.mask;
          stage_cfg_pkg::OFS_STATUS: next_st.rdata = {14'h0, st.divide_value,
                                       (st.active.min_speed >= st.active.max_speed),
                                       st.boot, dec_bad, link_fault, term_seen, st.seg_count};
          stage_cfg_pkg::OFS_DIVCMD: next_st.rdata = {24'h0, st.divide_value};
          default:                   next_st.rdata = 32'h0;
        endcase
      end
    end
    // register writes
    if (wr)
    begin
      if (prof_hit)
      begin
        case (prof_fld)
          stage_cfg_pkg::FLD_MIN:  next_st.prof[prof_idx].min_speed = wdata;
          stage_cfg_pkg::FLD_MAX:  next_st.prof[prof_idx].max_speed = wdata;
          stage_cfg_pkg::FLD_RAMP:
          begin
            // out-of-range ramp times are refused
            if (wdata[31:16] == 16'h0 && wdata[15:0] >= stage_cfg_pkg::RAMP_LO
                && wdata[15:0] <= stage_cfg_pkg::RAMP_HI)
            begin
              next_st.prof[prof_idx].ramp_ms = wdata[15:0];
            end
          end
          default: ;
        endcase
      end
      else
      begin
        case (addr)
          stage_cfg_pkg::OFS_CTRL:
          begin
            next_st.cfg = stage_cfg_pkg::cfg_t'(wdata[7:0]);
            // the spare interface code keeps the previous choice
            if (wdata[1:0] == 2'h3)
            begin
              next_st.cfg.host_link_choice = st.cfg.host_link_choice;
            end
          end
          stage_cfg_pkg::OFS_IP:     next_st.ip   = wdata;
          stage_cfg_pkg::OFS_MASK:   next_st.mask = wdata;
          stage_cfg_pkg::OFS_LOAD:   next_st.active = st.prof[st.cfg.speed_sel];
          stage_cfg_pkg::OFS_DIVCMD: ;  // divide follows the switch only
          default: ;
        endcase
      end
    end
    // flash timebase
    if (st.flash_cnt == 32'(FLASH_CYCLES - 1))
    begin
      next_st.flash_cnt = 32'h0;
      next_st.flash     = !st.flash;
    end
    else
    begin
      next_st.flash_cnt = st.flash_cnt + 32'h1;
    end
    // boot sequence of the master display
    case (st.boot)
      stage_cfg_pkg::ST_BOOT:
      begin
        // power-up profile follows the stored select
        next_st.active = st.prof[st.cfg.speed_sel];
        // the link is only usable once the terminator answers
        if (term_seen)
        begin
          next_st.boot = stage_cfg_pkg::ST_SHOW;
          next_st.cnt  = 32'h0;
        end
      end
      stage_cfg_pkg::ST_SHOW:
      begin
        // hold the axis count for the show time
        if (st.cnt == 32'(SHOW_CYCLES - 1))
        begin
          next_st.boot = stage_cfg_pkg::ST_RUN;
          next_st.cnt  = 32'h0;
        end
        else
        begin
          next_st.cnt = st.cnt + 32'h1;
        end
      end
      stage_cfg_pkg::ST_RUN: ;
      default: next_st.boot = stage_cfg_pkg::ST_BOOT;
    endcase
    // display and indicators
    next_st.seg_count = count_axes(axis_present);
    next_st.seg_on    = st.cfg.display_enable || abnormal;
    next_st.dot_on    = (st.boot == stage_cfg_pkg::ST_RUN) && st.flash
                        && (st.cfg.display_enable || abnormal);
    if (healthy)
    begin
      next_st.driver_led = st.flash && st.cfg.display_enable;
    end
    else
    begin
      next_st.driver_led = 1'b1;
    end
    // motor and divide
    next_st.motor_enable = master_link_up && !dec_bad;
    next_st.divide_value = dec_divide;
    // output polarity
    next_st.io_pin = st.cfg.idle_low ? io_active : ~io_active;
  end

  // state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= STATE_RESET;   // defaults incl. address, mask and divide
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs from state
  assign rdata                  = st.rdata;
  assign seg_count              = st.seg_count;
  assign seg_on                 = st.seg_on;
  assign dot_on                 = st.dot_on;
  assign driver_led             = st.driver_led;
  assign motor_enable           = st.motor_enable;
  assign divide_value           = st.divide_value;
  assign io_pin                 = st.io_pin;
  assign legacy_pulse_unit_mode = st.cfg.legacy_pulse_unit_mode;
  assign active_profile         = st.active;
  assign ip_addr                = st.ip;
  assign net_mask               = st.mask;

  // host interface enables, exactly one at a time
  assign host_en = {st.cfg.host_link_choice == stage_cfg_pkg::LINK_ETH,
                    st.cfg.host_link_choice == stage_cfg_pkg::LINK_USB,
                    st.cfg.host_link_choice == stage_cfg_pkg::LINK_SERIAL};

  // serial handshake
  assign rts      = st.cfg.serial_handshake_enable ? host_rx_ready : 1'b1;
  assign tx_allow = !st.cfg.serial_handshake_enable || cts;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_AXIS_COUNT: assert property (seg_count <= 4'h8)
    else $error("axis count above eight");
  AST_SHOW_TIME: assert property ((st.boot == stage_cfg_pkg::ST_SHOW
      ##1 st.boot == stage_cfg_pkg::ST_RUN) |-> $past(st.cnt) == 32'(SHOW_CYCLES - 1))
    else $error("count display left early or late");
  AST_DOT_RUN: assert property (dot_on |-> st.boot == stage_cfg_pkg::ST_RUN)
    else $error("dot flashing before run");
  AST_LED_STEADY: assert property ((!master_link_up || link_fault) |=> driver_led)
    else $error("indicator not steady on fault");
  AST_DIV_TABLE: assert property (divide_switch == 4'h7 |=> divide_value == 8'h14)
    else $error("divide decode wrong");
  AST_DIVCMD_IGNORED: assert property ((wr && addr == stage_cfg_pkg::OFS_DIVCMD
      && $stable(divide_switch)) |=> $stable(divide_value))
    else $error("divide changed by command");
  AST_HOST_ONEHOT: assert property ($onehot(host_en))
    else $error("host interface not one-hot");
  AST_RAMP_RANGE: assert property (active_profile.ramp_ms >= stage_cfg_pkg::RAMP_LO
      && active_profile.ramp_ms <= stage_cfg_pkg::RAMP_HI)
    else $error("ramp time out of range");
  // each pin follows its request one cycle later, inverted while idle high
  AST_POLARITY: assert property (##1 io_pin
      == ($past(st.cfg.idle_low) ? $past(io_active) : ~$past(io_active)))
    else $error("output polarity wrong");
  AST_BLANK: assert property ((!st.cfg.display_enable && !abnormal) |=> !seg_on)
    else $error("display lit in normal state while disabled");
  AST_ABNORMAL_LIT: assert property (abnormal |=> seg_on)
    else $error("display dark on abnormal condition");
  AST_FLOW: assert property ((st.cfg.serial_handshake_enable && !cts) |-> !tx_allow)
    else $error("sending against handshake");
  AST_BAD_DIV: assert property (divide_switch == stage_cfg_pkg::DIV_CODE_BAD
      |=> !motor_enable && driver_led)
    else $error("unusable divide not treated as fault");
  // healthy indicator goes dark while the display is switched off
  AST_LED_DARK: assert property ((healthy && !st.cfg.display_enable) |=> !driver_led)
    else $error("indicator lit in normal state while disabled");
  // reload command copies the selected profile into the active one
  AST_LOAD: assert property ((wr && addr == stage_cfg_pkg::OFS_LOAD)
      |=> active_profile == $past(st.prof[st.cfg.speed_sel]))
    else $error("profile reload wrong");

  COV_RUN: cover property (st.boot == stage_cfg_pkg::ST_SHOW ##1 st.boot == stage_cfg_pkg::ST_RUN);
  COV_DIVCMD: cover property (wr && addr == stage_cfg_pkg::OFS_DIVCMD);
  COV_BLANK: cover property (!st.cfg.display_enable ##1 !seg_on);
  COV_BAD_DIV: cover property (divide_switch == stage_cfg_pkg::DIV_CODE_BAD ##1 !motor_enable);
  // dot flashing seen in run
  COV_FLASH: cover property (dot_on ##1 !dot_on);

endmodule : stage_axis_config_logic
`default_nettype wire

// [verification/link_partner.sv]
// Purpose: far-side model of the chained axis units and the host serial line
// Assumes: bench sets the knobs just after a rising clock edge
// Notes:   outputs are registered, as a remote unit answers a cycle late
`timescale 1ns/1ps
`default_nettype none
module link_partner
(
  input  wire logic       clk,           // system clock
  input  wire logic [3:0] n_axes,        // units on the chain, 0..8
  input  wire logic       end_set,       // last unit has its end switch on
  input  wire logic       fault,         // link came up faulty
  input  wire logic       host_ok,       // host may accept data
  output logic      [7:0] axis_present,  // answering link addresses
  output logic            term_seen,     // terminating node found
  output logic            link_fault,    // faulty link seen
  output logic            cts            // host clear to send
);
  // units fill addresses from 0 upward in chain order
  // terminating node is known only with units and the end switch set
  always_ff @(posedge clk)
  begin
    axis_present <= 8'((16'h0001 << n_axes) - 16'h0001);
    term_seen    <= end_set && (n_axes != 4'h0);
    link_fault   <= fault;
    cts          <= host_ok;
  end
endmodule : link_partner
`default_nettype wire

// [verification/tb.sv]
// Purpose: self-checking bench of the stage axis configuration logic
// Assumes: short boot and flash counts set through parameters
// Notes:   random values from a fixed seed, corner cases by hand
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0;  // clock, reset, strobes
  logic [7:0]  addr = 8'h00, axis_present, divide_value, ctrl;
  logic [31:0] wdata = 32'h0, rdata, d, exp_r, ip_addr, net_mask;
  logic        master_link_up = 1'b1, host_rx_ready = 1'b0, end_set = 1'b1;
  logic        fault = 1'b0, host_ok = 1'b0, term_seen, link_fault, cts;
  logic [3:0]  divide_switch = 4'h7, io_active = 4'h0, n_axes = 4'h3, seg_count, io_pin;
  logic        seg_on, dot_on, driver_led, motor_enable, rts, tx_allow;
  logic        legacy_pulse_unit_mode;
  logic [2:0]  host_en;
  logic [31:0] ramp_try [5] = '{32'h3e9, 32'h0, 32'h1_0005, 32'h3e8, 32'h1};
  stage_cfg_pkg::profile_t active_profile;
  int          bad_count = 0, num_checks = 0, cycles = 0, dt, lt;

  always #50 clk = ~clk;  // 100 ns period

  stage_axis_config_logic #(.SHOW_CYCLES(20), .FLASH_CYCLES(4)) i_dut (.*);
  link_partner i_far (.*);

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // one-cycle register write and read
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : bus_rd

  // wait n edges, then sample in mid-cycle
  task automatic look(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : look

  // count changes of dot and driver indicator
  task automatic watch(output int dn, output int ln);
    logic pd, pl;
    dn = 0;
    ln = 0;
    repeat (12)
    begin
      pd = dot_on;
      pl = driver_led;
      @(negedge clk);
      dn += int'(dot_on !== pd);
      ln += int'(driver_led !== pl);
    end
  endtask : watch

  // switch position to divisions
  function automatic logic [7:0] exp_div(input logic [3:0] c);
    logic [7:0] t [16];
    t = '{8'h01, 8'h02, 8'h00, 8'h04, 8'h05, 8'h08, 8'h0a, 8'h14,
          8'h19, 8'h28, 8'h32, 8'h50, 8'h64, 8'h7d, 8'hc8, 8'hfa};
    return t[c];
  endfunction : exp_div

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end

  initial
  begin
    void'($urandom(32'h2d438e24));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    look(1);
    check(ip_addr, 32'hc0a8_0001);
    check(net_mask, 32'hffff_ff00);
    check(host_en, 32'h1);
    check(divide_value, 32'h14);
    check(active_profile.min_speed, 32'h2710);
    check(active_profile.max_speed, 32'h186a0);
    check(active_profile.ramp_ms, 32'hc8);
    look(30);
    check(seg_count, 32'h3);
    watch(dt, lt);
    check(32'(dt > 0), 32'h1);
    check(32'(lt > 0), 32'h1);
    // faulty link, then master missing: indicator steady
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      fault          <= (k == 0);
      master_link_up <= (k == 0);
      look(3);
      watch(dt, lt);
      check(driver_led, 32'h1);
      check(32'(lt), 32'h0);
    end
    @(posedge clk);
    fault          <= 1'b0;
    master_link_up <= 1'b1;
    n_axes         <= 4'h8;
    look(3);
    check(seg_count, 32'h8);
    for (int c = 0; c < 16; c++)
    begin
      @(posedge clk);
      divide_switch <= 4'(c);
      bus_wr(8'h14, 32'(exp_div(4'(c))));
      look(3);
      check(divide_value, exp_div(4'(c)));
      check(motor_enable, 32'(c != 2));
    end
    bus_wr(8'h14, 32'h1);
    look(0);
    check(divide_value, 32'hfa);
    // every host link, both handshakes and polarities
    for (int l = 0; l < 6; l++)
    begin
      ctrl = {2'h0, 1'b1, 1'(l % 2), 1'($urandom), 1'(l / 3), 2'(l % 3)};
      bus_wr(8'h00, 32'(ctrl));
      io_active     <= 4'($urandom);
      host_rx_ready <= 1'($urandom);
      host_ok       <= 1'($urandom);
      look(3);
      check(host_en, 32'(4'h1 << ctrl[1:0]));
      check(rts, ctrl[2] ? host_rx_ready : 1'b1);
      check(tx_allow, ctrl[2] ? host_ok : 1'b1);
      check(io_pin, io_active ^ {4{~ctrl[4]}});
      check(legacy_pulse_unit_mode, ctrl[3]);
    end
    // spare interface code keeps the ethernet choice, handshake off
    bus_wr(8'h00, 32'h23);
    look(1);
    check(host_en, 32'h4);
    check(rts, 32'h1);
    bus_wr(8'h00, 32'h04);
    look(3);
    check(seg_on, 32'h0);
    check(driver_led, 32'h0);
    @(posedge clk);
    fault <= 1'b1;
    look(3);
    check(seg_on, 32'h1);
    check(driver_led, 32'h1);
    @(posedge clk);
    fault <= 1'b0;
    bus_wr(8'h00, 32'h64);
    bus_wr(8'h50, 32'h1388);                     // min kept below max
    bus_wr(8'h0c, 32'h0);
    look(2);
    check(active_profile.min_speed, 32'h1388);
    check(active_profile.max_speed, 32'h493e0);
    exp_r = 32'hc8;
    foreach (ramp_try[i])
    begin
      bus_wr(8'h58, ramp_try[i]);
      bus_rd(8'h58, d);
      if (ramp_try[i] >= 32'h1 && ramp_try[i] <= 32'h3e8)
        exp_r = ramp_try[i];
      check(d, exp_r);
    end
    bus_rd(8'h5c, d);
    check(d, 32'h0);
    // status: divide 250, run state, terminator seen, eight axes
    bus_rd(8'h10, d);
    check(d, 32'h0003_e918);
    complete_run();
  end
endmodule : tb
`default_nettype wire
